/* include/fpma_pkg.sv */
// shared constants of the front panel mode and address block
// assumes a single 20 mhz system clock and an active high asynchronous reset
// Function
// - switch 1 is debug, switch 2 config; config wins, none means run
// - mode switches are captured once after power-up, later changes ignored
// - debug mode puts protocol on multidrop port, debugging on point-to-point port
// - configuration mode carries the configuration exchange on the point-to-point port
// - run mode without edit shows the current address, both digits steady
// - double press in run enters high-digit edit; high flashes, press adds one
// - 3 s hold in high edit enters low edit; low flashes, press adds one
// - 3 s hold in low edit commits address, flashes it three times
// - ten seconds without button activity abandons edit, old address shown again
// - address range is 0 to 99, kept as two decimal digits
// - first-row indicators blink while host port sends or receives, else dark
// - second-row indicators blink while field bus sends or receives, else dark
package fpma_pkg;
	localparam int          CLK_HZ       = 20_000_000;
	localparam int          CYC_PER_MS   = CLK_HZ / 1000;
	localparam int          DEBOUNCE_MS  = 20;
	localparam int          HOLD_MS      = 3000;
	localparam int          GAP_MS       = 400;
	localparam int          IDLE_MS      = 10_000;
	localparam int          FLASH_MS     = 250;
	localparam int          LED_MS       = 100;
	localparam int          DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
	localparam int          HOLD_CYC     = HOLD_MS * CYC_PER_MS;
	localparam int          GAP_CYC      = GAP_MS * CYC_PER_MS;
	localparam int          IDLE_CYC     = IDLE_MS * CYC_PER_MS;
	localparam int          FLASH_CYC    = FLASH_MS * CYC_PER_MS;
	localparam int          LED_CYC      = LED_MS * CYC_PER_MS;
	localparam logic [2:0]  SUCCESS_HALVES = 3'h6;
	localparam logic [1:0]  CAPTURE_WAIT   = 2'h3;
	localparam logic [3:0]  DIGIT_MAX      = 4'h9;
	localparam logic [3:0]  ADDR_HI_RST    = 4'h0;
	localparam logic [3:0]  ADDR_LO_RST    = 4'h0;
	localparam int          CNT_W          = 28;

	typedef enum logic [3:0] {
		FPMA_SHOW    = 4'h1,
		FPMA_EDIT_HI = 4'h2,
		FPMA_EDIT_LO = 4'h4,
		FPMA_SUCCESS = 4'h8
	} fpma_state_t;

	typedef enum logic [2:0] {
		FPMA_RUN    = 3'h1,
		FPMA_CONFIG = 3'h2,
		FPMA_DEBUG  = 3'h4
	} fpma_mode_t;
endpackage

/* design/fpma_blink.sv */
// one activity indicator: blinks while its path is busy, dark when idle
// assumes busy_in is a level from logic on the same clock
`timescale 1ns/1ps
module fpma_blink import fpma_pkg::*; #(
	parameter int HALF_CYC = LED_CYC
) (
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic busy_in,
	output logic      led_out
);
	logic [CNT_W-1:0] cnt;
	logic             phase;
	logic [CNT_W-1:0] next_cnt;
	logic             next_phase;
	logic             next_led;

	always_comb begin
		next_cnt   = '0;
		next_phase = 1'b1;
		if (busy_in) begin
			next_phase = phase;
			next_cnt   = cnt + 1'b1;
			if (cnt == CNT_W'(HALF_CYC - 1)) begin
				next_cnt   = '0;
				next_phase = ~phase;
			end
		end
		// lit one cycle after busy rises so short bursts still show
		next_led = busy_in & phase;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt     <= '0;
			phase   <= 1'b1;
			led_out <= 1'b0;
		end else begin
			cnt     <= next_cnt;
			phase   <= next_phase;
			led_out <= next_led;
		end
	end
endmodule

/* design/fpma_button.sv */
// button synchroniser, debouncer and press classifier
// assumes an active high raw button level from a pin, asynchronous to clk_in
`timescale 1ns/1ps
module fpma_button import fpma_pkg::*; #(
	parameter int DEB_CYC  = DEBOUNCE_CYC,
	parameter int HOLD_CYC = fpma_pkg::HOLD_CYC,
	parameter int GAP_CYC  = fpma_pkg::GAP_CYC
) (
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic button_in,
	output logic      single_out,
	output logic      double_out,
	output logic      long_out,
	output logic      activity_out
);
	logic [2:0]       sync;
	logic             deb;
	logic [CNT_W-1:0] deb_cnt;
	logic [CNT_W-1:0] held_cnt;
	logic [CNT_W-1:0] gap_cnt;
	logic             long_done;
	logic             pend;
	logic             next_deb;
	logic [CNT_W-1:0] next_deb_cnt;
	logic [CNT_W-1:0] next_held_cnt;
	logic [CNT_W-1:0] next_gap_cnt;
	logic             next_long_done;
	logic             next_pend;
	logic             next_single;
	logic             next_double;
	logic             next_long;
	logic             next_act;

	always_comb begin
		next_deb       = deb;
		next_deb_cnt   = '0;
		next_held_cnt  = '0;
		next_gap_cnt   = '0;
		next_long_done = long_done;
		next_pend      = pend;
		next_single    = 1'b0;
		next_double    = 1'b0;
		next_long      = 1'b0;
		next_act       = 1'b0;
		// stage 0 feeds stage 1 only; decisions use the agreeing later stages
		if (sync[1] == sync[2] && sync[2] != deb) begin
			next_deb_cnt = deb_cnt + 1'b1;
			if (deb_cnt == CNT_W'(DEB_CYC - 1)) begin
				next_deb     = sync[2];
				next_deb_cnt = '0;
				next_act     = 1'b1;
			end
		end
		if (deb) begin
			next_held_cnt = held_cnt;
			if (!long_done) begin
				next_held_cnt = held_cnt + 1'b1;
				if (held_cnt == CNT_W'(HOLD_CYC - 1)) begin
					next_long      = 1'b1;
					next_long_done = 1'b1;
					next_pend      = 1'b0;
				end
			end
			if (next_act) begin
				next_long_done = 1'b0;
				next_held_cnt  = '0;
				if (!long_done) begin
					// released short: second click makes a double
					next_double = pend;
					next_pend   = ~pend;
				end
			end
		end else if (pend) begin
			next_gap_cnt = gap_cnt + 1'b1;
			if (gap_cnt == CNT_W'(GAP_CYC - 1)) begin
				next_single = 1'b1;
				next_pend   = 1'b0;
			end
			// a new press clears the gap timer
			if (next_act) begin
				next_gap_cnt = '0;
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sync         <= 3'h0;
			deb          <= 1'b0;
			deb_cnt      <= '0;
			held_cnt     <= '0;
			gap_cnt      <= '0;
			long_done    <= 1'b0;
			pend         <= 1'b0;
			single_out   <= 1'b0;
			double_out   <= 1'b0;
			long_out     <= 1'b0;
			activity_out <= 1'b0;
		end else begin
			sync         <= {sync[1:0], button_in};
			deb          <= next_deb;
			deb_cnt      <= next_deb_cnt;
			held_cnt     <= next_held_cnt;
			gap_cnt      <= next_gap_cnt;
			long_done    <= next_long_done;
			pend         <= next_pend;
			single_out   <= next_single;
			double_out   <= next_double;
			long_out     <= next_long;
			activity_out <= next_act;
		end
	end
endmodule

/* design/fpma_top.sv */
// front panel: mode switches, address edit button, display and indicators
// assumes switch and button pins asynchronous; busy levels from clk_in logic
`timescale 1ns/1ps
module fpma_top import fpma_pkg::*; #(
	parameter int DEB_CYC   = DEBOUNCE_CYC,
	parameter int HOLD_CYC  = fpma_pkg::HOLD_CYC,
	parameter int GAP_CYC   = fpma_pkg::GAP_CYC,
	parameter int IDLE_CYC  = fpma_pkg::IDLE_CYC,
	parameter int FLASH_CYC = fpma_pkg::FLASH_CYC,
	parameter int LED_CYC   = fpma_pkg::LED_CYC
) (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       dip_debug_in,
	input  wire logic       dip_config_in,
	input  wire logic       button_in,
	input  wire logic       host_tx_busy_in,
	input  wire logic       host_rx_busy_in,
	input  wire logic       field_tx_busy_in,
	input  wire logic       field_rx_busy_in,
	output logic            mode_valid_out,
	output logic            mode_run_out,
	output logic            mode_config_out,
	output logic            mode_debug_out,
	output logic            proto_on_multidrop_out,
	output logic            debug_on_p2p_out,
	output logic            config_on_p2p_out,
	output logic [3:0]      digit_hi_out,
	output logic [3:0]      digit_lo_out,
	output logic            digit_hi_on_out,
	output logic            digit_lo_on_out,
	output logic            editing_out,
	output logic [6:0]      slave_addr_out,
	output logic            led_host_tx_out,
	output logic            led_host_rx_out,
	output logic            led_field_tx_out,
	output logic            led_field_rx_out
);
	// mode capture group
	logic [2:0]  dbg_sync;
	logic [2:0]  cfg_sync;
	logic [1:0]  cap_cnt;
	logic        captured;
	fpma_mode_t  mode;
	logic [1:0]  next_cap_cnt;
	logic        next_captured;
	fpma_mode_t  next_mode;

	always_comb begin
		next_cap_cnt  = cap_cnt;
		next_captured = captured;
		next_mode     = mode;
		if (!captured) begin
			if (cap_cnt != CAPTURE_WAIT) begin
				next_cap_cnt = cap_cnt + 2'h1;
			end else if (dbg_sync[1] == dbg_sync[2] && cfg_sync[1] == cfg_sync[2]) begin
				// taken once; the switches are never looked at again
				next_captured = 1'b1;
				if (cfg_sync[2]) begin
					next_mode = FPMA_CONFIG;
				end else if (dbg_sync[2]) begin
					next_mode = FPMA_DEBUG;
				end else begin
					next_mode = FPMA_RUN;
				end
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			dbg_sync <= 3'h0;
			cfg_sync <= 3'h0;
			cap_cnt  <= 2'h0;
			captured <= 1'b0;
			mode     <= FPMA_RUN;
		end else begin
			dbg_sync <= {dbg_sync[1:0], dip_debug_in};
			cfg_sync <= {cfg_sync[1:0], dip_config_in};
			cap_cnt  <= next_cap_cnt;
			captured <= next_captured;
			mode     <= next_mode;
		end
	end

	// button classification
	logic btn_single;
	logic btn_double;
	logic btn_long;
	logic btn_act;

	fpma_button #(
		.DEB_CYC  (DEB_CYC),
		.HOLD_CYC (HOLD_CYC),
		.GAP_CYC  (GAP_CYC)
	) u_button (
		.clk_in       (clk_in),
		.rst_in       (rst_in),
		.button_in    (button_in),
		.single_out   (btn_single),
		.double_out   (btn_double),
		.long_out     (btn_long),
		.activity_out (btn_act)
	);

	// address edit group
	fpma_state_t      state;
	logic [3:0]       addr_hi;
	logic [3:0]       addr_lo;
	logic [3:0]       edit_hi;
	logic [3:0]       edit_lo;
	logic [CNT_W-1:0] idle_cnt;
	logic [CNT_W-1:0] flash_cnt;
	logic             flash_phase;
	logic [2:0]       halves;
	fpma_state_t      next_state;
	logic [3:0]       next_addr_hi;
	logic [3:0]       next_addr_lo;
	logic [3:0]       next_edit_hi;
	logic [3:0]       next_edit_lo;
	logic [CNT_W-1:0] next_idle_cnt;
	logic [CNT_W-1:0] next_flash_cnt;
	logic             next_flash_phase;
	logic [2:0]       next_halves;
	logic [3:0]       next_disp_hi;
	logic [3:0]       next_disp_lo;
	logic             next_hi_on;
	logic             next_lo_on;
	logic [6:0]       next_addr_bin;

	function automatic logic [3:0] fpma_inc(input logic [3:0] d);
		// nine wraps to zero so the address never leaves 0..99
		if (d >= DIGIT_MAX) begin
			return 4'h0;
		end
		return d + 4'h1;
	endfunction

	always_comb begin
		next_state       = state;
		next_addr_hi     = addr_hi;
		next_addr_lo     = addr_lo;
		next_edit_hi     = edit_hi;
		next_edit_lo     = edit_lo;
		next_idle_cnt    = '0;
		next_flash_cnt   = flash_cnt + 1'b1;
		next_flash_phase = flash_phase;
		next_halves      = halves;
		if (flash_cnt == CNT_W'(FLASH_CYC - 1)) begin
			next_flash_cnt   = '0;
			next_flash_phase = ~flash_phase;
			next_halves      = halves + 3'h1;
		end
		case (state)
			FPMA_SHOW: begin
				if (mode == FPMA_RUN && captured && btn_double) begin
					next_state       = FPMA_EDIT_HI;
					next_edit_hi     = addr_hi;
					next_edit_lo     = addr_lo;
					next_flash_cnt   = '0;
					next_flash_phase = 1'b0;
				end
			end
			FPMA_EDIT_HI, FPMA_EDIT_LO: begin
				next_idle_cnt = btn_act ? '0 : idle_cnt + 1'b1;
				if (btn_single && state == FPMA_EDIT_HI) begin
					next_edit_hi = fpma_inc(edit_hi);
				end
				if (btn_single && state == FPMA_EDIT_LO) begin
					next_edit_lo = fpma_inc(edit_lo);
				end
				if (btn_long && state == FPMA_EDIT_HI) begin
					next_state = FPMA_EDIT_LO;
				end
				if (btn_long && state == FPMA_EDIT_LO) begin
					// commit, then three dark/lit pairs
					next_addr_hi     = edit_hi;
					next_addr_lo     = edit_lo;
					next_state       = FPMA_SUCCESS;
					next_flash_cnt   = '0;
					next_flash_phase = 1'b0;
					next_halves      = 3'h0;
				end
				if (idle_cnt == CNT_W'(IDLE_CYC - 1)) begin
					// stored digits untouched, so the old address returns
					next_state = FPMA_SHOW;
				end
			end
			FPMA_SUCCESS: begin
				// leave on the sixth half so no short extra dark blip follows
				if (next_halves == SUCCESS_HALVES) begin
					next_state = FPMA_SHOW;
				end
			end
			default: begin
				next_state = FPMA_SHOW;
			end
		endcase
		next_disp_hi = addr_hi;
		next_disp_lo = addr_lo;
		next_hi_on   = 1'b1;
		next_lo_on   = 1'b1;
		case (state)
			FPMA_EDIT_HI: begin
				next_disp_hi = edit_hi;
				next_disp_lo = edit_lo;
				next_hi_on   = flash_phase;
			end
			FPMA_EDIT_LO: begin
				next_disp_hi = edit_hi;
				next_disp_lo = edit_lo;
				next_lo_on   = flash_phase;
			end
			FPMA_SUCCESS: begin
				next_hi_on = flash_phase;
				next_lo_on = flash_phase;
			end
			default: begin
				next_hi_on = 1'b1;
			end
		endcase
		// widen before the product, a 4-bit product would wrap
		next_addr_bin = 7'(addr_hi) * 7'h0a + 7'(addr_lo);
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state           <= FPMA_SHOW;
			addr_hi         <= ADDR_HI_RST;
			addr_lo         <= ADDR_LO_RST;
			edit_hi         <= ADDR_HI_RST;
			edit_lo         <= ADDR_LO_RST;
			idle_cnt        <= '0;
			flash_cnt       <= '0;
			flash_phase     <= 1'b0;
			halves          <= 3'h0;
			digit_hi_out    <= ADDR_HI_RST;
			digit_lo_out    <= ADDR_LO_RST;
			digit_hi_on_out <= 1'b1;
			digit_lo_on_out <= 1'b1;
			editing_out     <= 1'b0;
			slave_addr_out  <= 7'h0;
		end else begin
			state           <= next_state;
			addr_hi         <= next_addr_hi;
			addr_lo         <= next_addr_lo;
			edit_hi         <= next_edit_hi;
			edit_lo         <= next_edit_lo;
			idle_cnt        <= next_idle_cnt;
			flash_cnt       <= next_flash_cnt;
			flash_phase     <= next_flash_phase;
			halves          <= next_halves;
			digit_hi_out    <= next_disp_hi;
			digit_lo_out    <= next_disp_lo;
			digit_hi_on_out <= next_hi_on;
			digit_lo_on_out <= next_lo_on;
			editing_out     <= (state == FPMA_EDIT_HI) || (state == FPMA_EDIT_LO);
			slave_addr_out  <= next_addr_bin;
		end
	end

	// port role outputs; held low until the switches have been captured
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			mode_valid_out         <= 1'b0;
			mode_run_out           <= 1'b0;
			mode_config_out        <= 1'b0;
			mode_debug_out         <= 1'b0;
			proto_on_multidrop_out <= 1'b0;
			debug_on_p2p_out       <= 1'b0;
			config_on_p2p_out      <= 1'b0;
		end else begin
			mode_valid_out         <= captured;
			mode_run_out           <= captured && mode == FPMA_RUN;
			mode_config_out        <= captured && mode == FPMA_CONFIG;
			mode_debug_out         <= captured && mode == FPMA_DEBUG;
			proto_on_multidrop_out <= captured && mode != FPMA_CONFIG;
			debug_on_p2p_out       <= captured && mode == FPMA_DEBUG;
			config_on_p2p_out      <= captured && mode == FPMA_CONFIG;
		end
	end

	// activity indicators, one instance per path
	fpma_blink #(.HALF_CYC(LED_CYC)) u_led_host_tx (
		.clk_in  (clk_in),
		.rst_in  (rst_in),
		.busy_in (host_tx_busy_in),
		.led_out (led_host_tx_out)
	);

	fpma_blink #(.HALF_CYC(LED_CYC)) u_led_host_rx (
		.clk_in  (clk_in),
		.rst_in  (rst_in),
		.busy_in (host_rx_busy_in),
		.led_out (led_host_rx_out)
	);

	fpma_blink #(.HALF_CYC(LED_CYC)) u_led_field_tx (
		.clk_in  (clk_in),
		.rst_in  (rst_in),
		.busy_in (field_tx_busy_in),
		.led_out (led_field_tx_out)
	);

	fpma_blink #(.HALF_CYC(LED_CYC)) u_led_field_rx (
		.clk_in  (clk_in),
		.rst_in  (rst_in),
		.busy_in (field_rx_busy_in),
		.led_out (led_field_rx_out)
	);
endmodule

/* tb/fpma_top_properties.sv */
// concurrent checks on the front panel block, bound to its top module
// assumes a single clock domain and active high asynchronous reset
`timescale 1ns/1ps
module fpma_top_checker (
	input wire logic       clk_in,
	input wire logic       rst_in,
	input wire logic       host_tx_busy_in,
	input wire logic       host_rx_busy_in,
	input wire logic       field_tx_busy_in,
	input wire logic       field_rx_busy_in,
	input wire logic       mode_valid_out,
	input wire logic       mode_run_out,
	input wire logic       mode_config_out,
	input wire logic       mode_debug_out,
	input wire logic       proto_on_multidrop_out,
	input wire logic       debug_on_p2p_out,
	input wire logic       config_on_p2p_out,
	input wire logic [3:0] digit_hi_out,
	input wire logic [3:0] digit_lo_out,
	input wire logic       editing_out,
	input wire logic [6:0] slave_addr_out,
	input wire logic       led_host_tx_out,
	input wire logic       led_host_rx_out,
	input wire logic       led_field_tx_out,
	input wire logic       led_field_rx_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	a_mode_one_hot: assert property (mode_valid_out |->
		$onehot({mode_run_out, mode_config_out, mode_debug_out})) else $error("mode not one-hot");
	a_mode_held: assert property (mode_valid_out && $past(mode_valid_out) |->
		$stable({mode_run_out, mode_config_out, mode_debug_out})) else $error("mode changed");
	a_debug_roles: assert property (mode_debug_out |->
		proto_on_multidrop_out && debug_on_p2p_out && !config_on_p2p_out) else $error("debug roles");
	a_config_roles: assert property (mode_config_out |->
		config_on_p2p_out && !debug_on_p2p_out) else $error("config roles");
	a_addr_range: assert property (slave_addr_out <= 7'h63 && digit_hi_out <= 4'h9 &&
		digit_lo_out <= 4'h9) else $error("address out of range");
	a_edit_run_only: assert property ($rose(editing_out) |-> mode_run_out)
		else $error("edit outside run mode");
	a_host_lit: assert property ($rose(host_tx_busy_in) |=> led_host_tx_out)
		else $error("host tx led not lit");
	a_host_dark: assert property (!host_rx_busy_in |=> !led_host_rx_out)
		else $error("host rx led lit while idle");
	a_field_lit: assert property ($rose(field_rx_busy_in) |=> led_field_rx_out)
		else $error("field rx led not lit");
	a_field_dark: assert property (!field_tx_busy_in |=> !led_field_tx_out)
		else $error("field tx led lit while idle");
endmodule

bind fpma_top fpma_top_checker u_chk (.clk_in(clk_in), .rst_in(rst_in),
	.host_tx_busy_in(host_tx_busy_in), .host_rx_busy_in(host_rx_busy_in),
	.field_tx_busy_in(field_tx_busy_in), .field_rx_busy_in(field_rx_busy_in),
	.mode_valid_out(mode_valid_out), .mode_run_out(mode_run_out),
	.mode_config_out(mode_config_out), .mode_debug_out(mode_debug_out),
	.proto_on_multidrop_out(proto_on_multidrop_out), .debug_on_p2p_out(debug_on_p2p_out),
	.config_on_p2p_out(config_on_p2p_out), .digit_hi_out(digit_hi_out),
	.digit_lo_out(digit_lo_out), .editing_out(editing_out), .slave_addr_out(slave_addr_out),
	.led_host_tx_out(led_host_tx_out), .led_host_rx_out(led_host_rx_out),
	.led_field_tx_out(led_field_tx_out), .led_field_rx_out(led_field_rx_out));

/* tb/fpma_operator.sv */
// operator model: presses the button in single, double and long patterns
// assumes the shortened debounce 4, gap 16 and hold 40 cycles of the bench
`timescale 1ns/1ps
module fpma_operator (
	input  wire logic clk_in,
	output logic      button_out
);
	initial button_out = 1'b0;

	task automatic press(input int n);
		@(posedge clk_in) button_out <= 1'b1;
		repeat (n) @(posedge clk_in);
		button_out <= 1'b0;
	endtask

	// wait past the gap so the press is classified as single
	task automatic click();
		press(10);
		repeat (35) @(posedge clk_in);
		@(negedge clk_in);
	endtask

	// release shorter than the gap joins two presses
	task automatic dbl();
		press(10);
		repeat (8) @(posedge clk_in);
		press(10);
		repeat (35) @(posedge clk_in);
		@(negedge clk_in);
	endtask

	task automatic hold(input int n);
		press(n);
		repeat (35) @(posedge clk_in);
		// return off the edge so callers read settled outputs
		@(negedge clk_in);
	endtask
endmodule

/* tb/test_fpma_top.sv */
// self-checking bench for the front panel block
// assumes shortened timing parameters; operator model drives the button
`timescale 1ns/1ps
module test_fpma_top;
	logic       clk_in = 1'b0;
	logic       rst_in = 1'b1;
	logic       dip_debug_in = 1'b0;
	logic       dip_config_in = 1'b0;
	logic       button;
	logic [3:0] busy = 4'h0;
	logic [3:0] led;
	logic       valid, run, cfg, dbg, proto, dbg_p2p, cfg_p2p;
	logic [3:0] hi, lo;
	logic       hi_on, lo_on, editing;
	logic [6:0] addr;
	int         fail_count = 0;
	int         total_checks = 0;
	int         cyc = 0;

	// shortened timing so a whole edit fits in a few thousand cycles
	localparam int TB_DEB   = 4;
	localparam int TB_HOLD  = 40;
	localparam int TB_GAP   = 16;
	localparam int TB_IDLE  = 200;
	localparam int TB_FLASH = 8;
	localparam int TB_LED   = 4;

	fpma_operator op (.clk_in(clk_in), .button_out(button));

	fpma_top #(.DEB_CYC(TB_DEB), .HOLD_CYC(TB_HOLD), .GAP_CYC(TB_GAP), .IDLE_CYC(TB_IDLE),
		.FLASH_CYC(TB_FLASH), .LED_CYC(TB_LED)) DUT (.clk_in(clk_in), .rst_in(rst_in),
		.dip_debug_in(dip_debug_in),
		.dip_config_in(dip_config_in), .button_in(button), .host_tx_busy_in(busy[0]),
		.host_rx_busy_in(busy[1]), .field_tx_busy_in(busy[2]), .field_rx_busy_in(busy[3]),
		.mode_valid_out(valid), .mode_run_out(run), .mode_config_out(cfg),
		.mode_debug_out(dbg), .proto_on_multidrop_out(proto), .debug_on_p2p_out(dbg_p2p),
		.config_on_p2p_out(cfg_p2p), .digit_hi_out(hi), .digit_lo_out(lo),
		.digit_hi_on_out(hi_on), .digit_lo_on_out(lo_on), .editing_out(editing),
		.slave_addr_out(addr), .led_host_tx_out(led[0]), .led_host_rx_out(led[1]),
		.led_field_tx_out(led[2]), .led_field_rx_out(led[3]));

	initial begin
		forever #25 clk_in = ~clk_in;
	end

	// hang guard, far above the few thousand cycles the tests need
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			finish_test();
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// counts dark-phase starts of each digit over n cycles
	task automatic sample(input int n, output int hf, output int lf);
		logic ph, pl;
		hf = 0;
		lf = 0;
		@(negedge clk_in);
		ph = hi_on;
		pl = lo_on;
		repeat (n) begin
			@(negedge clk_in);
			if (ph && !hi_on) hf++;
			if (pl && !lo_on) lf++;
			ph = hi_on;
			pl = lo_on;
		end
	endtask

	task automatic t_modes();
		logic d, c;
		for (int i = 3; i >= 0; i--) begin
			d = i[0];
			c = i[1];
			@(posedge clk_in) rst_in <= 1'b1;
			dip_debug_in <= d;
			dip_config_in <= c;
			repeat (20) @(posedge clk_in);
			rst_in <= 1'b0;
			repeat (10) @(posedge clk_in);
			@(posedge clk_in) dip_debug_in <= !d;
			dip_config_in <= !c;
			repeat (10) @(posedge clk_in);
			@(negedge clk_in);
			check({valid, run, cfg, dbg}, {1'b1, !c && !d, c, d && !c});
			check({run, cfg, dbg}, {!c && !d, c, d && !c});
			check({proto, dbg_p2p}, {!c, d && !c});
			check(cfg_p2p, c);
			if (c || d) begin
				op.dbl();
				check(editing, 1'b0);
			end
		end
		$display("test modes done");
	endtask

	task automatic t_leds();
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_in) busy <= 4'h1 << i;
			@(posedge clk_in);
			@(negedge clk_in);
			check(led, 4'h1 << i);
			repeat (4) @(posedge clk_in);
			@(negedge clk_in);
			check(led[i], 1'b0);
			@(posedge clk_in) busy <= 4'h0;
			@(posedge clk_in);
			@(negedge clk_in);
			check(led, 4'h0);
		end
		$display("test leds done");
	endtask

	task automatic t_edit();
		int hf, lf;
		sample(40, hf, lf);
		check({hi, lo}, 8'h00);
		check(8'(hf + lf), 8'h00);
		op.dbl();
		check({editing, hi}, {1'b1, 4'h0});
		sample(40, hf, lf);
		check({hf != 0, lf != 0}, 2'h2);
		repeat (3) op.click();
		check(hi, 4'h3);
		op.hold(60);
		check(editing, 1'b1);
		sample(40, hf, lf);
		check({hf != 0, lf != 0}, 2'h1);
		repeat (11) op.click();
		check({hi, lo}, 8'h31);
		fork
			op.hold(60);
			sample(130, hf, lf);
		join
		check(8'(hf), 8'h03);
		check({editing, addr}, 8'h1f);
		sample(40, hf, lf);
		check({hi, lo}, 8'h31);
		check(8'(hf + lf), 8'h00);
		$display("test edit done");
	endtask

	task automatic t_idle();
		op.dbl();
		op.click();
		check({editing, hi}, {1'b1, 4'h4});
		repeat (230) @(posedge clk_in);
		@(negedge clk_in);
		check(editing, 1'b0);
		check({hi, lo}, 8'h31);
		check(addr, 8'h1f);
		$display("test idle done");
	endtask

	initial begin
		t_modes();
		t_leds();
		t_edit();
		t_idle();
		finish_test();
	end
endmodule
